// *** aps_amp_pin_supervisor.sv ***
// Top of the amplifier pin supervisor: mute, thermal, clip, idle and registers
//
// How it works
// - A low pair enable unmutes its two channels; open or high mutes them.
// - Warning one rises above 100 C and warning two above 115 C on any channel.
// - After warning two, every channel stays muted until all are below 105 C.
// - Both warning pins are open-drain, pulled low while their warning holds.
// - A low parallel-power input selects parallel mode and syncs paired stages.
// - In parallel mode only the first input of each pair feeds both channels.
// - Clip pins are active-low open-collector outputs, pulled up externally to 3V3.
// - Clip asserts on clipping, current limit, or input signal while muted.
// - The idle pin decodes as open auto, 10k resistor high idle, ground low idle.
// - Automatic idle starts in the high idle setting.
// - Auto idle goes low above 130 V rail-to-rail and back high below 120 V.
// - Forced settings select highest or lowest idle regardless of rail.
// - Channel temperatures are signed 8-bit degrees Celsius.
// - The ready pin goes high only while all four channels are muted, for any cause.
`timescale 1ns/100ps
module aps_amp_pin_supervisor (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pair_a_enable_n,
    input wire logic pair_b_enable_n,
    input wire logic parallel_power_n,
    input wire aps_pkg::aps_idle_pin_t idleAdjPin,
    input wire logic [31:0] chTemps,
    input wire logic tempValid,
    input wire logic [15:0] rail_pos,
    input wire logic [15:0] rail_neg,
    input wire logic railValid,
    input wire logic [3:0] chClipRaw,
    input wire logic [3:0] chCurLimit,
    input wire logic [3:0] chSignalPresent,
    input wire aps_pkg::aps_avreq_t avReq,
    output aps_pkg::aps_avrsp_t avRsp,
    output aps_pkg::aps_od_t thermal_warn_low_n,
    output aps_pkg::aps_od_t thermal_warn_high_n,
    output aps_pkg::aps_od_t pair_a_clip_n,
    output aps_pkg::aps_od_t pair_b_clip_n,
    output aps_pkg::aps_od_t amplifying_n,
    output logic [3:0] chMute,
    output logic parallelMode,
    output logic [3:0] chInputSel,
    output logic lowIdle,
    output logic irq
);
    typedef struct packed {
        logic warnLow;
        logic warnHigh;
        logic thermMute;
        logic [3:0] mute;
        logic parallel;
        logic [3:0] inSel;
        logic clipA;
        logic clipB;
        logic ampOn;
        logic [4:0] irqStat;
        logic [4:0] irqMask;
        logic swMute;
        logic irqOut;
        logic prevIdle;
        logic [31:0] rdData;
        logic rdAck;
    } aps_top_st_t;
    aps_top_st_t st_q, st_d;

    logic [2:0] pinSync;
    aps_pkg::aps_idle_pin_t idleSync;
    logic idleLow;
    logic [4:0] events;
    logic [15:0] railSpan;

    // Any channel above a threshold, temperatures taken as signed
    function automatic logic anyAbove(input logic [31:0] t, input logic signed [7:0] lim);
        logic r;
        r = 1'b0;
        for (int i = 0; i < aps_pkg::NUM_CH; i++)
            r |= ($signed(t[i*8 +: 8]) > lim);
        return r;
    endfunction

    function automatic logic allBelow(input logic [31:0] t, input logic signed [7:0] lim);
        logic r;
        r = 1'b1;
        for (int i = 0; i < aps_pkg::NUM_CH; i++)
            r &= ($signed(t[i*8 +: 8]) < lim);
        return r;
    endfunction

    // Enable and parallel pins idle high so a floating enable pin reads as mute and a floating parallel pin as no parallel mode
    aps_sync #(.W(3), .RST_VAL(3'h7)) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .din({parallel_power_n, pair_b_enable_n, pair_a_enable_n}),
        .dout(pinSync)
    );

    logic [1:0] idleRaw;
    aps_sync #(.W(2), .RST_VAL(2'h0)) u_idle_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .din(idleAdjPin),
        .dout(idleRaw)
    );
    assign idleSync = aps_pkg::aps_idle_pin_t'(idleRaw);

    // Rail span; a negative rail sample is its magnitude below ground
    assign railSpan = 16'(rail_pos + rail_neg);

    aps_idle_ctrl u_idle (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .idlePin(idleSync),
        .railVolts(railSpan),
        .railValid(railValid),
        .lowIdle(idleLow)
    );

    always_comb
    begin
        st_d = st_q;
        events = '0;
        if (ce)
        begin
            if (tempValid)
            begin
                st_d.warnLow = anyAbove(chTemps, aps_pkg::TEMP_WARN_LOW_C);
                st_d.warnHigh = anyAbove(chTemps, aps_pkg::TEMP_WARN_HIGH_C);
                if (st_d.warnHigh)
                    st_d.thermMute = 1'b1;
                else if (allBelow(chTemps, aps_pkg::TEMP_RELEASE_C))
                    st_d.thermMute = 1'b0;
            end
            st_d.mute[1:0] = {2{pinSync[0] | st_d.thermMute | st_q.swMute}};
            st_d.mute[3:2] = {2{pinSync[1] | st_d.thermMute | st_q.swMute}};
            st_d.parallel = ~pinSync[2];
            // Second channel of a pair follows the first input in parallel mode
            st_d.inSel = st_d.parallel ? 4'h5 : 4'hF;
            // Host must mask these while muted; they chatter then
            st_d.clipA = |((chClipRaw[1:0] | chCurLimit[1:0]) | (chSignalPresent[1:0] & st_d.mute[1:0]));
            st_d.clipB = |((chClipRaw[3:2] | chCurLimit[3:2]) | (chSignalPresent[3:2] & st_d.mute[3:2]));
            st_d.ampOn = ~&st_d.mute;
            st_d.prevIdle = idleLow;

            events[aps_pkg::EV_WARN_LOW] = st_d.warnLow & ~st_q.warnLow;
            events[aps_pkg::EV_WARN_HIGH] = st_d.warnHigh & ~st_q.warnHigh;
            events[aps_pkg::EV_THERM_MUTE] = st_d.thermMute & ~st_q.thermMute;
            events[aps_pkg::EV_CLIP] = (st_d.clipA | st_d.clipB) & ~(st_q.clipA | st_q.clipB);
            events[aps_pkg::EV_IDLE_CHG] = idleLow ^ st_q.prevIdle;

            // Avalon slave, one wait cycle on reads, writes accepted at once
            st_d.rdAck = 1'b0;
            if (avReq.write)
            begin
                case (avReq.address)
                    aps_pkg::ADDR_IRQ_STAT: st_d.irqStat = st_q.irqStat & ~avReq.writedata[4:0];
                    aps_pkg::ADDR_IRQ_MASK: st_d.irqMask = avReq.writedata[4:0];
                    aps_pkg::ADDR_CTRL: st_d.swMute = avReq.writedata[0];
                    default: st_d.irqMask = st_q.irqMask;
                endcase
            end
            else if (avReq.read && !st_q.rdAck)
            begin
                st_d.rdAck = 1'b1;
                case (avReq.address)
                    aps_pkg::ADDR_STATUS: st_d.rdData = {22'h000000, st_q.ampOn, idleLow, st_q.parallel,
                        st_q.clipB, st_q.clipA, st_q.mute[2], st_q.mute[0], st_q.thermMute,
                        st_q.warnHigh, st_q.warnLow};
                    aps_pkg::ADDR_IRQ_STAT: st_d.rdData = {27'h0000000, st_q.irqStat};
                    aps_pkg::ADDR_IRQ_MASK: st_d.rdData = {27'h0000000, st_q.irqMask};
                    aps_pkg::ADDR_CTRL: st_d.rdData = {31'h00000000, st_q.swMute};
                    default: st_d.rdData = aps_pkg::UNMAPPED_RD;
                endcase
            end
            // New event wins over a same-cycle clear
            st_d.irqStat = st_d.irqStat | events;
            st_d.irqOut = |(st_d.irqStat & st_d.irqMask);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.mute <= 4'hF;
            st_q.inSel <= 4'hF;
            st_q.irqMask <= aps_pkg::IRQ_MASK_RST;
            st_q.swMute <= aps_pkg::CTRL_SWMUTE_RST;
        end
        else
            st_q <= st_d;
    end

    // Open-drain pins: oeN low only while pulling the line low
    assign thermal_warn_low_n = '{out: 1'b0, oeN: ~st_q.warnLow};
    assign thermal_warn_high_n = '{out: 1'b0, oeN: ~st_q.warnHigh};
    assign pair_a_clip_n = '{out: 1'b0, oeN: ~st_q.clipA};
    assign pair_b_clip_n = '{out: 1'b0, oeN: ~st_q.clipB};
    assign amplifying_n = '{out: 1'b0, oeN: ~st_q.ampOn};
    assign chMute = st_q.mute;
    assign parallelMode = st_q.parallel;
    assign chInputSel = st_q.inSel;
    assign lowIdle = idleLow;
    assign irq = st_q.irqOut;
    assign avRsp = '{readdata: st_q.rdData, waitrequest: avReq.read & ~st_q.rdAck};
endmodule

// *** aps_pkg.sv ***
// Constants and carrier types for the amplifier pin supervisor
package aps_pkg;
    localparam int NUM_CH = 4;
    localparam int TEMP_W = 8;
    localparam int RAIL_W = 16;
    // Temperatures in degrees Celsius, signed
    localparam logic signed [7:0] TEMP_WARN_LOW_C = 8'sh64;   // 100
    localparam logic signed [7:0] TEMP_WARN_HIGH_C = 8'sh73;  // 115
    localparam logic signed [7:0] TEMP_RELEASE_C = 8'sh69;    // 105
    // Rail-to-rail voltage in volts
    localparam logic [15:0] RAIL_UP_V = 16'h0082;   // 130
    localparam logic [15:0] RAIL_DOWN_V = 16'h0078; // 120
    // Register map, byte addresses on the Avalon word bus
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    localparam logic [3:0] ADDR_CTRL = 4'hC;
    // Interrupt bit positions; the status register shares only bits 0 to 2
    localparam int EV_WARN_LOW = 0;
    localparam int EV_WARN_HIGH = 1;
    localparam int EV_THERM_MUTE = 2;
    localparam int EV_CLIP = 3;
    localparam int EV_IDLE_CHG = 4;
    localparam int EV_W = 5;
    localparam logic [4:0] IRQ_MASK_RST = 5'h00;
    localparam logic CTRL_SWMUTE_RST = 1'b0;
    localparam logic [31:0] UNMAPPED_RD = 32'h00000000;

    // Idle-adjust pin decoded levels
    typedef enum logic [1:0] {IDLE_PIN_OPEN, IDLE_PIN_RES, IDLE_PIN_GND} aps_idle_pin_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } aps_avreq_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } aps_avrsp_t;

    // Open-drain pin: level pulled low when drive asserted, oe low while driving
    typedef struct packed {
        logic out;
        logic oeN;
    } aps_od_t;
endpackage

// *** aps_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module aps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } aps_sync_st_t;
    aps_sync_st_t st_q, st_d;

    always_comb
    begin
        st_d = st_q;
        if (ce)
        begin
            st_d.s1 = din;
            st_d.s2 = st_q.s1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_q <= {RST_VAL, RST_VAL};
        else
            st_q <= st_d;
    end

    assign dout = st_q.s2;
endmodule

// *** aps_idle_ctrl.sv ***
// Idle-current selection from the adjust pin or rail hysteresis
`timescale 1ns/100ps
module aps_idle_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire aps_pkg::aps_idle_pin_t idlePin,
    input wire logic [15:0] railVolts,
    input wire logic railValid,
    output logic lowIdle
);
    typedef struct packed {
        logic autoLow;
        logic lowIdle;
    } aps_idle_st_t;
    aps_idle_st_t st_q, st_d;

    always_comb
    begin
        st_d = st_q;
        if (ce)
        begin
            // Hysteresis band keeps the stage from toggling on rail ripple
            if (railValid && railVolts > aps_pkg::RAIL_UP_V)
                st_d.autoLow = 1'b1;
            else if (railValid && railVolts < aps_pkg::RAIL_DOWN_V)
                st_d.autoLow = 1'b0;
            case (idlePin)
                aps_pkg::IDLE_PIN_OPEN: st_d.lowIdle = st_d.autoLow;
                aps_pkg::IDLE_PIN_RES: st_d.lowIdle = 1'b0;
                aps_pkg::IDLE_PIN_GND: st_d.lowIdle = 1'b1;
                default: st_d.lowIdle = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign lowIdle = st_q.lowIdle;
endmodule

// *** aps_host_model.sv ***
// Host model: slow temperature converter feeding the supervisor
`timescale 1ns/100ps
module aps_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] tempSet,
    output logic [31:0] chTemps,
    output logic tempValid
);
    logic [1:0] phase_q;
    // Bus flips between samples so stale data is never mistaken for a reading
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase_q <= 2'h0;
            tempValid <= 1'b0;
            chTemps <= 32'h00000000;
        end
        else
        begin
            phase_q <= phase_q + 2'h1;
            tempValid <= phase_q == 2'h3;
            chTemps <= (phase_q == 2'h3) ? tempSet : ~chTemps;
        end
    end
endmodule

// *** aps_checker.sv ***
// Assertion checker for the amplifier pin supervisor
`timescale 1ns/100ps
module aps_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pair_a_enable_n,
    input wire logic parallel_power_n,
    input wire aps_pkg::aps_idle_pin_t idleAdjPin,
    input wire logic [31:0] chTemps,
    input wire logic tempValid,
    input wire logic [3:0] chClipRaw,
    input wire aps_pkg::aps_od_t thermal_warn_low_n,
    input wire aps_pkg::aps_od_t thermal_warn_high_n,
    input wire aps_pkg::aps_od_t pair_a_clip_n,
    input wire aps_pkg::aps_od_t amplifying_n,
    input wire logic [3:0] chMute,
    input wire logic parallelMode,
    input wire logic [3:0] chInputSel,
    input wire logic lowIdle
);
    logic hot;
    // Strict compare: a channel sitting on the threshold warns nothing
    always_comb
    begin
        hot = 1'b0;
        for (int i = 0; i < 4; i++)
            hot = hot | ($signed(chTemps[8*i+:8]) > aps_pkg::TEMP_WARN_LOW_C);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);
    a_warn_set: assert property (tempValid && hot |-> ##[1:2] !thermal_warn_low_n.oeN)
        else $error("warning not driven");
    a_warn_free: assert property (tempValid && !hot |-> ##[1:2] thermal_warn_low_n.oeN)
        else $error("warning not released");
    a_high_mutes: assert property (!thermal_warn_high_n.oeN |-> chMute == 4'hF)
        else $error("hot but not muted");
    a_pair_mute: assert property (pair_a_enable_n [*4] |-> chMute[1:0] == 2'h3)
        else $error("pair not muted");
    a_parallel_sel: assert property (!parallel_power_n [*4] |-> parallelMode && chInputSel == 4'h5)
        else $error("parallel not taken");
    a_clip_drive: assert property (chClipRaw[0] |-> ##[1:2] !pair_a_clip_n.oeN)
        else $error("clip not driven");
    a_idle_forced: assert property ((idleAdjPin == aps_pkg::IDLE_PIN_GND) [*4] |-> lowIdle)
        else $error("low idle not forced");
    a_ready_mute: assert property (amplifying_n.oeN == (&chMute))
        else $error("ready pin wrong");
    a_pin_low: assert property (!thermal_warn_low_n.out && !pair_a_clip_n.out && !amplifying_n.out)
        else $error("pin level not low");
    c_hot: cover property (tempValid && hot);
    c_parallel: cover property (parallelMode);
    c_clip: cover property (!pair_a_clip_n.oeN);
endmodule
bind aps_amp_pin_supervisor aps_checker aps_checker_inst (.clk, .rst, .ce, .pair_a_enable_n, .parallel_power_n,
    .idleAdjPin, .chTemps, .tempValid, .chClipRaw, .thermal_warn_low_n, .thermal_warn_high_n, .pair_a_clip_n,
    .amplifying_n, .chMute, .parallelMode, .chInputSel, .lowIdle);

// *** aps_amp_pin_supervisor_tb.sv ***
// Self-checking bench for the amplifier pin supervisor
`timescale 1ns/100ps
module aps_amp_pin_supervisor_tb;
    logic clk, rst, ce, pair_a_enable_n, pair_b_enable_n, parallel_power_n, tempValid, railValid;
    logic parallelMode, lowIdle, irq;
    aps_pkg::aps_idle_pin_t idleAdjPin;
    logic [31:0] chTemps, tempSet, ts;
    logic [15:0] rail_pos, rail_neg;
    logic [3:0] chClipRaw, chCurLimit, chSignalPresent, chMute, chInputSel;
    aps_pkg::aps_avreq_t avReq;
    aps_pkg::aps_avrsp_t avRsp;
    aps_pkg::aps_od_t wLo, wHi, cA, cB, amp;
    int fails, checks_done, hot;
    logic [31:0] expQ[$];
    int tv[7] = '{100, 101, 115, 116, 110, 105, 104};
    logic [9:0] tx[7] = '{10'h200, 10'h201, 10'h201, 10'h01F, 10'h01D, 10'h01D, 10'h201};
    logic [12:0] cv[3] = '{13'h0040, 13'h0100, 13'h1008};
    logic [9:0] cx[3] = '{10'h240, 10'h220, 10'h250};
    logic [17:0] iv[7] = '{18'h00064, 18'h00082, 18'h00083, 18'h00078, 18'h00077, 18'h20064, 18'h1008C};
    logic [9:0] ix[7] = '{10'h200, 10'h200, 10'h300, 10'h300, 10'h200, 10'h300, 10'h200};
    aps_amp_pin_supervisor aps_amp_pin_supervisor_inst (.clk, .rst, .ce, .pair_a_enable_n, .pair_b_enable_n,
        .parallel_power_n, .idleAdjPin, .chTemps, .tempValid, .rail_pos, .rail_neg, .railValid, .chClipRaw,
        .chCurLimit, .chSignalPresent, .avReq, .avRsp, .thermal_warn_low_n(wLo), .thermal_warn_high_n(wHi),
        .pair_a_clip_n(cA), .pair_b_clip_n(cB), .amplifying_n(amp), .chMute, .parallelMode, .chInputSel,
        .lowIdle, .irq);
    aps_host_model aps_host_model_inst (.clk, .rst, .tempSet, .chTemps, .tempValid);
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avReq.address <= a;
        avReq.write <= wr;
        avReq.read <= !wr;
        avReq.writedata <= d;
        @(posedge clk);
        while (avRsp.waitrequest !== 1'b0)
            @(posedge clk);
        avReq.write <= 1'b0;
        avReq.read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h00000000);
    endtask
    // Long enough for two pin sync stages plus a full sample period
    task automatic st;
        repeat (12) @(posedge clk);
    endtask
    task automatic chk(input logic e);
        @(negedge clk);
        checks_done++;
        if (irq !== e)
        begin
            fails++;
            $display("[ERR] irq exp %b got %b", e, irq);
        end
        @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (avReq.read === 1'b1 && avRsp.waitrequest === 1'b0 && expQ.size() > 0)
        begin
            checks_done++;
            if (avRsp.readdata !== expQ[0])
            begin
                fails++;
                $display("[ERR] reg %h exp %h got %h", avReq.address, expQ[0], avRsp.readdata);
            end
            void'(expQ.pop_front());
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("[ERR] watchdog exp done got hang");
        give_verdict;
    end
    initial
    begin
        {rst, ce, pair_a_enable_n, pair_b_enable_n, parallel_power_n, railValid} = 6'h3F;
        {chClipRaw, chCurLimit, chSignalPresent, tempSet} = 44'h00000000000;
        {rail_pos, rail_neg} = 32'h00000064;
        idleAdjPin = aps_pkg::IDLE_PIN_OPEN;
        avReq = 38'h0000000000;
        void'($urandom(57));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(aps_pkg::ADDR_STATUS, 32'h00000018);
        rd(aps_pkg::ADDR_IRQ_MASK, {27'h0000000, aps_pkg::IRQ_MASK_RST});
        pair_a_enable_n <= 1'b0;
        st;
        rd(aps_pkg::ADDR_STATUS, 32'h00000210);
        pair_b_enable_n <= 1'b0;
        st;
        rd(aps_pkg::ADDR_STATUS, 32'h00000200);
        $display("test enable done");
        hot = $urandom_range(3, 0);
        for (int i = 0; i < 7; i++)
        begin
            for (int c = 0; c < 4; c++)
                ts[8*c+:8] = (c == hot) ? 8'(tv[i]) : 8'($urandom_range(109, 0) - 10);
            tempSet <= ts;
            st;
            rd(aps_pkg::ADDR_STATUS, {22'h000000, tx[i]});
        end
        tempSet <= 32'h00000000;
        parallel_power_n <= 1'b0;
        st;
        rd(aps_pkg::ADDR_STATUS, 32'h00000280);
        parallel_power_n <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            {pair_b_enable_n, chClipRaw, chCurLimit, chSignalPresent} <= cv[i];
            st;
            // Clip under mute is only compared here; a host monitor would mask it then
            rd(aps_pkg::ADDR_STATUS, {22'h000000, cx[i]});
        end
        {pair_b_enable_n, chClipRaw, chCurLimit, chSignalPresent} <= 13'h0000;
        for (int i = 0; i < 7; i++)
        begin
            idleAdjPin <= aps_pkg::aps_idle_pin_t'(iv[i][17:16]);
            rail_neg <= iv[i][15:0];
            st;
            rd(aps_pkg::ADDR_STATUS, {22'h000000, ix[i]});
        end
        $display("test pins done");
        bus(1'b1, aps_pkg::ADDR_IRQ_MASK, 32'h00000001);
        bus(1'b1, aps_pkg::ADDR_IRQ_STAT, 32'h0000001F);
        chk(1'b0);
        tempSet <= 32'h00000065;
        st;
        chk(1'b1);
        rd(aps_pkg::ADDR_IRQ_STAT, 32'h00000001);
        bus(1'b1, aps_pkg::ADDR_IRQ_MASK, 32'h00000000);
        chk(1'b0);
        bus(1'b1, aps_pkg::ADDR_IRQ_MASK, 32'h00000001);
        chk(1'b1);
        bus(1'b1, aps_pkg::ADDR_IRQ_STAT, 32'h00000001);
        chk(1'b0);
        bus(1'b1, aps_pkg::ADDR_CTRL, 32'h00000001);
        bus(1'b1, 4'h1, 32'hFFFFFFFF);
        rd(4'h1, aps_pkg::UNMAPPED_RD);
        rd(aps_pkg::ADDR_CTRL, 32'h00000001);
        rd(aps_pkg::ADDR_STATUS, 32'h00000019);
        $display("test registers done");
        // Frozen state must still show the old warning on the first read after enable returns
        ce <= 1'b0;
        tempSet <= 32'h00000000;
        st;
        ce <= 1'b1;
        rd(aps_pkg::ADDR_STATUS, 32'h00000019);
        st;
        rd(aps_pkg::ADDR_STATUS, 32'h00000018);
        $display("test freeze done");
        give_verdict;
    end
endmodule
